// [logic/pmb_pkg.sv]
`default_nettype none
// ==========================================================
// shared constants and types
package pmb_pkg;
  // clock and bus rates
  localparam int CLK_HZ = 25_000_000;
  localparam int SLOW_BUS_HZ = 100_000;
  localparam int MAX_BUS_HZ = 400_000;
  localparam int FAST_CYC = CLK_HZ / SLOW_BUS_HZ;
  localparam int HALF_MIN = (CLK_HZ + 2 * MAX_BUS_HZ - 1) / (2 * MAX_BUS_HZ);
  localparam int HALF_DEF = 32;
  // device address and command codes
  localparam logic [6:0] DEV_ADDR = 7'h4f;
  localparam logic [7:0] CMD_OPER = 8'h01;
  localparam logic [7:0] CMD_VSET = 8'h21;
  localparam logic [7:0] CMD_GCFG = 8'hd1;
  localparam logic [7:0] CMD_HS = 8'hef;
  localparam int NSLOT = 3;
  localparam logic [1:0] SLOT_OPER = 2'h0;
  localparam logic [1:0] SLOT_VSET = 2'h1;
  localparam logic [1:0] SLOT_GCFG = 2'h2;
  // handshake_status and global_config fields
  localparam int HS_NOT_TRANS = 4;
  localparam int HS_NOT_CALC = 5;
  localparam int HS_NOT_BUSY = 6;
  localparam logic [7:0] HS_MASK = 8'h70;
  localparam logic [7:0] HS_RST = 8'h70;
  localparam int GCFG_STRETCH = 1;
  localparam logic [7:0] GCFG_RST = 8'h09;
  localparam logic [7:0] BUSY_DATA = 8'hff;
  // internal processor timing in clock cycles
  localparam int CONV_CYC = 64;
  localparam int EXEC_CYC = 32;
  localparam int TRANS_CYC = 512;
  // controller registers, byte offsets and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_RES = 4'h4;
  localparam logic [3:0] REG_IRQ = 4'h8;
  localparam logic [3:0] REG_MASK = 4'hc;
  localparam int CTL_RD = 16;
  localparam int CTL_SAFE = 17;
  localparam int CTL_GO = 31;
  localparam int RES_NACK = 8;
  localparam int RES_BUSY = 9;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NACK = 1;
  localparam int IRQ_ALERT = 2;
  localparam int NIRQ = 3;
  localparam int RETRIES = 3;
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_HOLD, S_TX, S_RACK} pmb_sst_t;
  typedef enum logic [1:0] {K_ADDR, K_CMD, K_DATA} pmb_kind_t;
  typedef enum logic [1:0] {P_IDLE, P_CONV, P_EXEC} pmb_pst_t;
endpackage : pmb_pkg
`default_nettype wire

// [logic/pmb_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// open-drain bus between controller and device
interface pmb_link_if;
  logic h_scl_o, h_scl_oe, h_sda_o, h_sda_oe;
  logic d_scl_o, d_scl_oe, d_sda_o, d_sda_oe, d_alert_o, d_alert_oe;
  logic scl, sda, alert_n;
  // wired-and: a line is low while any enabled driver pulls it low
  assign scl = !((h_scl_oe & !h_scl_o) | (d_scl_oe & !d_scl_o));
  assign sda = !((h_sda_oe & !h_sda_o) | (d_sda_oe & !d_sda_o));
  assign alert_n = !(d_alert_oe & !d_alert_o);
  modport host (input scl, sda, alert_n, output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe);
  modport dev (input scl, sda, output d_scl_o, d_scl_oe, d_sda_o, d_sda_oe, d_alert_o, d_alert_oe);
endinterface : pmb_link_if
`default_nettype wire

// [logic/pmb_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// two-stage synchroniser for pin inputs
module pmb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  // reset to idle-high so no false edge shows after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= RST;
      q_o <= RST;
    end
    else if (ce_i)
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : pmb_sync
`default_nettype wire

// [logic/pmb_dev.sv]
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - one newest-data buffer per writable command
// - bus write stores data, flags command pending
// - bus intake and processor run independently
// - pending commands may execute out of order
// - calc flag low while conversion pending
// - not-busy flag low during any operation
// - not-transition flag low while output moves
// - busy: nack, or all-ones read data
// - busy: fault with alert, or stretch
// - stretching needs global_config bit 1
// - stretch only at 100kHz or above and enabled
// - all flags set: accept without busy reply
// - unsupported or read-only commands are nacked
// - host polls flags before each write launched with the safe bit set
// - host honours stretched clock above 100kHz
// - host retries after busy nack
// - host never exceeds 400kHz
module pmb_dev #(
  parameter logic [6:0] ADDR = pmb_pkg::DEV_ADDR,
  parameter int CONV = pmb_pkg::CONV_CYC,
  parameter int EXEC = pmb_pkg::EXEC_CYC,
  parameter int TRANS = pmb_pkg::TRANS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  pmb_link_if.dev link,
  input wire logic busy_nack_i,
  input wire logic vout_moving_i,
  output logic exec_o,
  output logic [7:0] exec_cmd_o,
  output logic [7:0] exec_data_o,
  output logic [7:0] gcfg_o,
  output logic [7:0] handshake_o,
  output logic busy_fault_o
);
  localparam logic [8:0] FAST_C = 9'(pmb_pkg::FAST_CYC);

  // ==========================================================
  // command table
  function automatic logic is_wr(input logic [7:0] c);
    is_wr = (c == pmb_pkg::CMD_OPER) | (c == pmb_pkg::CMD_VSET) | (c == pmb_pkg::CMD_GCFG);
  endfunction : is_wr

  function automatic logic [1:0] slot_ix(input logic [7:0] c);
    slot_ix = (c == pmb_pkg::CMD_VSET) ? pmb_pkg::SLOT_VSET :
              (c == pmb_pkg::CMD_GCFG) ? pmb_pkg::SLOT_GCFG : pmb_pkg::SLOT_OPER;
  endfunction : slot_ix

  function automatic logic [7:0] cmd_of(input logic [1:0] s);
    cmd_of = (s == pmb_pkg::SLOT_VSET) ? pmb_pkg::CMD_VSET :
             (s == pmb_pkg::SLOT_GCFG) ? pmb_pkg::CMD_GCFG : pmb_pkg::CMD_OPER;
  endfunction : cmd_of

  // ==========================================================
  // pin sampling
  logic [1:0] sy;
  logic scl_p_q, sda_p_q;
  logic [8:0] per_q;
  logic fast_q;

  pmb_sync #(.W(2), .RST(2'h3)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({link.scl, link.sda}),
    .q_o(sy)
  );

  // previous sample for edge and start/stop detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else if (ce_i)
    begin
      scl_p_q <= sy[1];
      sda_p_q <= sy[0];
    end
  end

  // bus speed: clock period measured rise to rise, saturating
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      per_q <= '0;
      fast_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (sy[1] & !scl_p_q)
      begin
        per_q <= '0;
        fast_q <= per_q < FAST_C;
      end
      else if (per_q != FAST_C)
        per_q <= per_q + 9'h1;
    end
  end

  // ==========================================================
  // slave byte engine
  pmb_pkg::pmb_sst_t st_q, nxt_q;
  pmb_pkg::pmb_kind_t kind_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, cmd_q, tx_q, hs_q, gcfg_q;
  logic ack_q, fault_q;
  logic [pmb_pkg::NSLOT-1:0] pend_q;
  logic [pmb_pkg::NSLOT-1:0][7:0] buf_q;

  wire rise = sy[1] & !scl_p_q;
  wire fall = !sy[1] & scl_p_q;
  wire start = sy[1] & scl_p_q & sda_p_q & !sy[0];
  wire stop = sy[1] & scl_p_q & !sda_p_q & sy[0];
  wire byte_end = (st_q == pmb_pkg::S_RX) & fall & (cnt_q == 4'h8);
  wire busy = !hs_q[pmb_pkg::HS_NOT_BUSY];
  wire stretch_ok = gcfg_q[pmb_pkg::GCFG_STRETCH] & fast_q;
  wire addr_hit = sh_q[7:1] == ADDR;
  wire rd_ok = (cmd_q == pmb_pkg::CMD_HS) | is_wr(cmd_q);
  wire rd_busy = busy & (cmd_q != pmb_pkg::CMD_HS);
  wire rd_take = rd_ok & !(rd_busy & busy_nack_i);
  wire rd_go = byte_end & (kind_q == pmb_pkg::K_ADDR) & addr_hit & sh_q[0];
  wire data_end = byte_end & (kind_q == pmb_pkg::K_DATA) & is_wr(cmd_q);
  // writes land unless nack mode refuses them; held writes land once idle
  wire wr = (data_end & (!busy | (!stretch_ok & !busy_nack_i))) | ((st_q == pmb_pkg::S_HOLD) & !busy);
  wire [1:0] wr_slot = slot_ix(cmd_q);
  wire fault_ev = (data_end & busy & !stretch_ok) | (rd_go & rd_busy);
  wire hs_clr = rd_go & (cmd_q == pmb_pkg::CMD_HS);
  // busy reads answer all ones unless the command is the status itself
  wire [7:0] rd_val = (cmd_q == pmb_pkg::CMD_HS) ? hs_q : busy ? pmb_pkg::BUSY_DATA : buf_q[wr_slot];

  // byte framing; start and stop win over any state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= pmb_pkg::S_IDLE;
      nxt_q <= pmb_pkg::S_IDLE;
      kind_q <= pmb_pkg::K_ADDR;
      cnt_q <= '0;
      sh_q <= '0;
      cmd_q <= '0;
      tx_q <= '1;
      ack_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (start)
      begin
        st_q <= pmb_pkg::S_RX;
        kind_q <= pmb_pkg::K_ADDR;
        cnt_q <= '0;
      end
      else if (stop)
        st_q <= pmb_pkg::S_IDLE;
      else
      begin
        unique case (st_q)
          pmb_pkg::S_IDLE: ;
          pmb_pkg::S_RX:
          begin
            if (rise)
            begin
              sh_q <= {sh_q[6:0], sy[0]};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (byte_end)
            begin
              cnt_q <= '0;
              st_q <= pmb_pkg::S_ACK;
              nxt_q <= pmb_pkg::S_IDLE;
              ack_q <= 1'b1;
              unique case (kind_q)
                pmb_pkg::K_ADDR:
                begin
                  if (!addr_hit)
                    st_q <= pmb_pkg::S_IDLE;
                  else if (sh_q[0])
                  begin
                    ack_q <= rd_take;
                    tx_q <= rd_val;
                    nxt_q <= rd_take ? pmb_pkg::S_TX : pmb_pkg::S_IDLE;
                  end
                  else
                  begin
                    kind_q <= pmb_pkg::K_CMD;
                    nxt_q <= pmb_pkg::S_RX;
                  end
                end
                pmb_pkg::K_CMD:
                begin
                  cmd_q <= sh_q;
                  ack_q <= is_wr(sh_q) | (sh_q == pmb_pkg::CMD_HS);
                  kind_q <= pmb_pkg::K_DATA;
                  nxt_q <= (is_wr(sh_q) | (sh_q == pmb_pkg::CMD_HS)) ? pmb_pkg::S_RX : pmb_pkg::S_IDLE;
                end
                default:
                begin
                  if (!is_wr(cmd_q))
                    ack_q <= 1'b0;
                  else if (busy & stretch_ok)
                    st_q <= pmb_pkg::S_HOLD;
                  else
                    ack_q <= !busy | !busy_nack_i;
                end
              endcase
            end
          end
          // clock held low until the not-busy flag is set
          pmb_pkg::S_HOLD: if (!busy) st_q <= pmb_pkg::S_ACK;
          pmb_pkg::S_ACK: if (fall) st_q <= nxt_q;
          pmb_pkg::S_TX:
          begin
            if (rise)
              cnt_q <= cnt_q + 4'h1;
            else if (fall)
            begin
              if (cnt_q == 4'h8)
                st_q <= pmb_pkg::S_RACK;
              else
                tx_q <= {tx_q[6:0], 1'b1};
            end
          end
          pmb_pkg::S_RACK: if (rise) st_q <= pmb_pkg::S_IDLE;
        endcase
      end
    end
  end

  // busy fault: set wins over the clearing status read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fault_q <= 1'b0;
    else if (ce_i)
      fault_q <= fault_ev | (fault_q & !hs_clr);
  end

  // ==========================================================
  // command buffers, one entry per writable command
  pmb_pkg::pmb_pst_t pst_q;
  logic [1:0] sel, cur_q;
  logic [7:0] fdata_q;
  logic [15:0] pcnt_q, trans_q;
  wire fetch = (pst_q == pmb_pkg::P_IDLE) & (|pend_q);

  // a write in the fetch cycle keeps the entry pending, so no data is lost
  for (genvar g = 0; g < pmb_pkg::NSLOT; g++)
  begin : g_slot
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        pend_q[g] <= 1'b0;
        buf_q[g] <= '0;
      end
      else if (ce_i)
      begin
        if (wr & (wr_slot == 2'(g)))
        begin
          pend_q[g] <= 1'b1;
          buf_q[g] <= sh_q;
        end
        else if (fetch & (sel == 2'(g)))
          pend_q[g] <= 1'b0;
      end
    end
  end

  // fixed priority pick: lowest entry first, not arrival order
  always_comb
  begin
    sel = '0;
    for (int i = pmb_pkg::NSLOT - 1; i >= 0; i--)
      if (pend_q[i])
        sel = 2'(i);
  end

  // ==========================================================
  // internal processor: fetch, convert, execute
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pst_q <= pmb_pkg::P_IDLE;
      cur_q <= '0;
      fdata_q <= '0;
      pcnt_q <= '0;
      trans_q <= '0;
      exec_o <= 1'b0;
      exec_cmd_o <= '0;
      exec_data_o <= '0;
      gcfg_q <= pmb_pkg::GCFG_RST;
    end
    else if (ce_i)
    begin
      exec_o <= 1'b0;
      if (trans_q != 16'h0)
        trans_q <= trans_q - 16'h1;
      unique case (pst_q)
        pmb_pkg::P_IDLE:
        begin
          if (fetch)
          begin
            cur_q <= sel;
            fdata_q <= buf_q[sel];
            pcnt_q <= 16'(CONV - 1);
            pst_q <= pmb_pkg::P_CONV;
          end
        end
        pmb_pkg::P_CONV:
        begin
          pcnt_q <= pcnt_q - 16'h1;
          if (pcnt_q == 16'h0)
          begin
            pcnt_q <= 16'(EXEC - 1);
            pst_q <= pmb_pkg::P_EXEC;
          end
        end
        default:
        begin
          pcnt_q <= pcnt_q - 16'h1;
          if (pcnt_q == 16'h0)
          begin
            pst_q <= pmb_pkg::P_IDLE;
            exec_o <= 1'b1;
            exec_cmd_o <= cmd_of(cur_q);
            exec_data_o <= fdata_q;
            if (cur_q == pmb_pkg::SLOT_GCFG)
              gcfg_q <= fdata_q;
            else
              trans_q <= 16'(TRANS);
          end
        end
      endcase
    end
  end

  // handshake flags recomputed every enabled cycle, so they recover on their own
  wire out_moving = (trans_q != 16'h0) | vout_moving_i;
  wire not_calc = !(|pend_q) & (pst_q != pmb_pkg::P_CONV);
  wire not_busy = !(|pend_q) & (pst_q == pmb_pkg::P_IDLE) & !out_moving;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hs_q <= pmb_pkg::HS_RST;
    else if (ce_i)
      hs_q <= {1'b0, not_busy, not_calc, !out_moving, 4'h0};
  end

  // ==========================================================
  // pins and user outputs
  assign link.d_sda_o = 1'b0;
  assign link.d_scl_o = 1'b0;
  assign link.d_alert_o = 1'b0;
  assign link.d_sda_oe = ((st_q == pmb_pkg::S_ACK) & ack_q) | ((st_q == pmb_pkg::S_TX) & !tx_q[7]);
  assign link.d_scl_oe = st_q == pmb_pkg::S_HOLD;
  assign link.d_alert_oe = fault_q;
  assign gcfg_o = gcfg_q;
  assign handshake_o = hs_q;
  assign busy_fault_o = fault_q;
endmodule : pmb_dev
`default_nettype wire

// [logic/pmb_host.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bus controller with wishbone command registers
module pmb_host #(
  parameter int HALF = pmb_pkg::HALF_DEF,
  parameter logic [6:0] ADDR = pmb_pkg::DEV_ADDR,
  parameter int RETRY = pmb_pkg::RETRIES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  pmb_link_if.host link
);
  // half period never below the 400kHz floor
  localparam int HEFF = (HALF < pmb_pkg::HALF_MIN) ? pmb_pkg::HALF_MIN : HALF;
  localparam logic [7:0] HLD = 8'(HEFF - 1);

  logic [2:0] sy;
  logic [7:0] c_data_q, c_cmd_q, rx_q, res_q;
  logic c_rd_q, c_safe_q, busy_q, poll_q, nk_q, res_nk_q, run_q;
  logic [3:0] tries_q, bit_q;
  logic [2:0] step_q;
  logic [1:0] ph_q;
  logic [7:0] tim_q;
  logic [pmb_pkg::NIRQ-1:0] irq_q, mask_q;

  pmb_sync #(.W(3), .RST(3'h7)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({link.scl, link.sda, link.alert_n}),
    .q_o(sy)
  );

  // ==========================================================
  // bit engine decode
  wire txn_rd = poll_q | c_rd_q;
  wire [7:0] txn_cmd = poll_q ? pmb_pkg::CMD_HS : c_cmd_q;
  wire k_start = (step_q == 3'h0) | ((step_q == 3'h3) & txn_rd);
  wire k_stop = step_q == 3'h6;
  wire [1:0] last_ph = k_start ? 2'h3 : k_stop ? 2'h2 : 2'h1;
  wire [7:0] byte_v = (step_q == 3'h1) ? {ADDR, 1'b0} : (step_q == 3'h2) ? txn_cmd :
                      (step_q == 3'h3) ? c_data_q : (step_q == 3'h4) ? {ADDR, 1'b1} : 8'hff;
  wire obit = bit_q[3] | byte_v[~bit_q[2:0]];
  // timer waits while a device stretches the released clock
  wire tick = run_q & !((ph_q == 2'h1) & !sy[2]);
  wire adv = tick & (tim_q == 8'h0);
  wire done = adv & k_stop & (ph_q == last_ph);
  wire retry = nk_q & (tries_q != 4'h0);

  // ==========================================================
  // wishbone decode
  wire acc = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire wr_ctl = acc & wb_we_i & (wb_adr_i == pmb_pkg::REG_CTRL) & !busy_q;
  wire go = wr_ctl & wb_sel_i[3] & wb_dat_i[pmb_pkg::CTL_GO];
  wire safe_now = wb_sel_i[2] ? wb_dat_i[pmb_pkg::CTL_SAFE] : c_safe_q;
  wire launch = go | (done & (poll_q | retry));
  wire fin = done & !poll_q & !retry;
  wire rd_irq = acc & !wb_we_i & (wb_adr_i == pmb_pkg::REG_IRQ);
  wire [pmb_pkg::NIRQ-1:0] irq_set = {!sy[0], fin & nk_q, fin};
  wire [31:0] rd_mux = (wb_adr_i == pmb_pkg::REG_CTRL) ? {busy_q, 13'h0, c_safe_q, c_rd_q, c_cmd_q, c_data_q} :
                       (wb_adr_i == pmb_pkg::REG_RES) ? {22'h0, busy_q, res_nk_q, res_q} :
                       (wb_adr_i == pmb_pkg::REG_IRQ) ? {29'h0, irq_q} :
                       (wb_adr_i == pmb_pkg::REG_MASK) ? {29'h0, mask_q} : 32'h0;

  // register slave: one-cycle ack, unmapped offsets read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      {c_data_q, c_cmd_q, c_rd_q, c_safe_q} <= '0;
      mask_q <= '0;
      irq_q <= '0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= acc;
      if (acc & !wb_we_i)
        wb_dat_o <= rd_mux;
      if (wr_ctl & wb_sel_i[0])
        c_data_q <= wb_dat_i[7:0];
      if (wr_ctl & wb_sel_i[1])
        c_cmd_q <= wb_dat_i[15:8];
      if (wr_ctl & wb_sel_i[2])
        {c_safe_q, c_rd_q} <= wb_dat_i[pmb_pkg::CTL_SAFE:pmb_pkg::CTL_RD];
      if (acc & wb_we_i & (wb_adr_i == pmb_pkg::REG_MASK) & wb_sel_i[0])
        mask_q <= wb_dat_i[pmb_pkg::NIRQ-1:0];
      irq_q <= irq_set | (irq_q & {pmb_pkg::NIRQ{!rd_irq}});
    end
  end

  // sequencing: poll flags, then write, retrying refused writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_q <= 1'b0;
      poll_q <= 1'b0;
      tries_q <= '0;
      res_q <= '0;
      res_nk_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (go)
      begin
        busy_q <= 1'b1;
        poll_q <= safe_now;
        tries_q <= 4'(RETRY);
      end
      else if (done & poll_q)
        poll_q <= nk_q | ((rx_q & pmb_pkg::HS_MASK) != pmb_pkg::HS_MASK);
      else if (done & retry)
      begin
        tries_q <= tries_q - 4'h1;
        poll_q <= c_safe_q;
      end
      else if (fin)
      begin
        busy_q <= 1'b0;
        res_q <= rx_q;
        res_nk_q <= nk_q;
      end
    end
  end

  // bit engine: start, bytes with ack, stop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_q <= 1'b0;
      {step_q, bit_q, ph_q} <= '0;
      tim_q <= '0;
      nk_q <= 1'b0;
      rx_q <= '0;
    end
    else if (ce_i)
    begin
      if (launch)
      begin
        run_q <= 1'b1;
        {step_q, bit_q, ph_q} <= '0;
        tim_q <= HLD;
        nk_q <= 1'b0;
      end
      else if (done)
        run_q <= 1'b0;
      else if (adv)
      begin
        tim_q <= HLD;
        ph_q <= ph_q + 2'h1;
        if (ph_q == last_ph)
        begin
          ph_q <= 2'h0;
          if (k_start)
            step_q <= step_q + 3'h1;
          else if (!bit_q[3])
          begin
            bit_q <= bit_q + 4'h1;
            if (step_q == 3'h5)
              rx_q <= {rx_q[6:0], sy[1]};
          end
          else
          begin
            bit_q <= 4'h0;
            if ((step_q != 3'h5) & sy[1])
            begin
              nk_q <= 1'b1;
              step_q <= 3'h6;
            end
            else
              step_q <= ((step_q == 3'h3) & !txn_rd) ? 3'h6 : step_q + 3'h1;
          end
        end
      end
      else if (tick)
        tim_q <= tim_q - 8'h1;
    end
  end

  // pin drive from engine phase
  assign link.h_scl_o = 1'b0;
  assign link.h_sda_o = 1'b0;
  assign link.h_scl_oe = run_q & (k_start ? ((ph_q == 2'h0) | (ph_q == 2'h3)) : (ph_q == 2'h0));
  assign link.h_sda_oe = run_q & (k_start ? ph_q[1] : k_stop ? !ph_q[1] : !obit);
  assign irq_o = |(irq_q & mask_q);
endmodule : pmb_host
`default_nettype wire

// [verif/pmb_props.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// link and flag checks beside the joined bus
module pmb_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic h_scl_oe,
  input wire logic d_scl_oe,
  input wire logic d_alert_oe,
  input wire logic scl,
  input wire logic [7:0] handshake_o,
  input wire logic [7:0] gcfg_o,
  input wire logic busy_fault_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_alert_fault: assert property ($rose(busy_fault_o) |-> d_alert_oe && !$past(handshake_o[6])) else $error("alert");
  a_stretch_off: assert property (!gcfg_o[1] |-> !d_scl_oe) else $error("stretch off");
  a_stretch_busy: assert property ($rose(d_scl_oe) |-> !$past(handshake_o[6])) else $error("stretch idle");
  a_stretch_low: assert property ($rose(d_scl_oe) |-> !$past(scl)) else $error("stretch high");
  a_calc_busy: assert property (!handshake_o[5] |-> !handshake_o[6]) else $error("calc");
  a_flag_layout: assert property ((handshake_o & 8'h8f) == 8'h00) else $error("layout");
  a_calc_back: assert property ($fell(handshake_o[5]) |-> ##[1:1000] handshake_o[5]) else $error("calc");
  a_host_low: assert property ($rose(h_scl_oe) |=> h_scl_oe [*8]) else $error("fast");
endmodule : pmb_props
`default_nettype wire

// [verif/test_pmbus_command_buffer_busy_handshake.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// both ends joined, controller driven over wishbone
module test_pmbus_command_buffer_busy_handshake;
  localparam logic [7:0] VS = pmb_pkg::CMD_VSET;
  logic clk_i, rst_i, cyc, we, bn, vm, ce, exec_o, busy_fault_o, irq_o, ack;
  logic [3:0] adr, sel;
  logic [31:0] dat, rdat, q;
  logic [7:0] exec_cmd_o, exec_data_o, gcfg_o, handshake_o, ex_dat, d;
  int errors, tests_run;
  pmb_link_if link();
  // retries off so a busy refusal stays visible
  pmb_host #(.RETRY(0)) i_pmb_host (.clk_i, .rst_i, .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o, .link(link));
  // long transition so a follow-up transfer meets a busy device
  pmb_dev #(.CONV(400), .EXEC(8), .TRANS(2500)) i_pmb_dev (.clk_i, .rst_i, .ce_i(ce), .link(link),
    .busy_nack_i(bn), .vout_moving_i(vm), .exec_o, .exec_cmd_o, .exec_data_o, .gcfg_o, .handshake_o, .busy_fault_o);
  pmb_props i_pmb_props (.clk_i, .rst_i, .h_scl_oe(link.h_scl_oe), .d_scl_oe(link.d_scl_oe),
    .d_alert_oe(link.d_alert_oe), .scl(link.scl), .handshake_o, .gcfg_o, .busy_fault_o);
  always #20 clk_i = !clk_i;
  // newest executed data
  always @(posedge clk_i)
  begin
    if (exec_o === 1'b1)
      ex_dat <= exec_data_o;
  end
  // ==========================================================
  // checks and bus tasks
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chk1
  task automatic fail();
    errors++;
    $display("wrong value at %0t: timeout", $time);
    wrap_up();
  endtask : fail
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
    int n;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= v;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
    if (n >= 20)
      fail();
  endtask : wb
  // m is {safe, read}; waits for the controller to finish
  task automatic cmd(input logic [1:0] m, input logic [7:0] c, input logic [7:0] v);
    int n;
    wb(1'b1, pmb_pkg::REG_CTRL, {1'b1, 13'h0000, m, c, v});
    n = 0;
    do
    begin
      wb(1'b0, pmb_pkg::REG_RES, 32'h0000_0000);
      n++;
    end
    while (q[9] !== 1'b0 && n < 9000);
    if (n >= 9000)
      fail();
  endtask : cmd
  task automatic ready();
    int n;
    n = 0;
    while (handshake_o !== pmb_pkg::HS_RST && n < 9000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 9000)
      fail();
  endtask : ready
  // ==========================================================
  // main sequence
  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'h0;
    ce = 1'b1;
    dat = 32'h0000_0000;
    bn = 1'b0;
    vm = 1'b0;
    errors = 0;
    tests_run = 0;
    void'($urandom(32'h910c));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(handshake_o, pmb_pkg::HS_RST);
    chk1(gcfg_o[1], 1'b0);
    vm <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk1(handshake_o[4], 1'b0);
    // enable low freezes the flag although its cause is gone
    ce <= 1'b0;
    vm <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk1(handshake_o[4], 1'b0);
    ce <= 1'b1;
    wb(1'b1, pmb_pkg::REG_MASK, 32'h0000_0007);
    $display("reset test done");
    for (int i = 0; i < 2; i++)
    begin
      d = 8'($urandom);
      cmd(2'b10, VS, d);
      chk1(q[8] | busy_fault_o, 1'b0);
      chk1(irq_o, 1'b1);
      wb(1'b0, pmb_pkg::REG_IRQ, 32'h0000_0000);
      chk1(q[0] & !irq_o, 1'b1);
      ready();
      chk(ex_dat, d);
      chk(exec_cmd_o, VS);
    end
    $display("safe write test done");
    cmd(2'b10, VS, d);
    cmd(2'b00, VS, ~d);
    chk1(q[8], 1'b0);
    chk1(busy_fault_o, 1'b1);
    cmd(2'b01, VS, 8'h00);
    chk(q[7:0], pmb_pkg::BUSY_DATA);
    ready();
    chk(ex_dat, ~d);
    cmd(2'b01, pmb_pkg::CMD_HS, 8'h00);
    chk1(busy_fault_o, 1'b0);
    $display("busy accept test done");
    bn <= 1'b1;
    cmd(2'b10, VS, d);
    cmd(2'b01, VS, 8'h00);
    chk1(q[8] & busy_fault_o, 1'b1);
    wb(1'b0, pmb_pkg::REG_IRQ, 32'h0000_0000);
    chk(q[7:0] & 8'h06, 8'h06);
    cmd(2'b01, pmb_pkg::CMD_HS, 8'h00);
    ready();
    for (int i = 0; i < 2; i++)
    begin
      cmd(2'b10, (i == 0) ? 8'h55 : pmb_pkg::CMD_HS, 8'($urandom));
      chk1(q[8], 1'b1);
    end
    $display("nack test done");
    cmd(2'b10, pmb_pkg::CMD_GCFG, 8'h0b);
    ready();
    chk(gcfg_o, 8'h0b);
    cmd(2'b10, VS, d);
    cmd(2'b00, VS, ~d);
    chk1(q[8] | busy_fault_o, 1'b0);
    ready();
    chk(ex_dat, ~d);
    $display("stretch test done");
    wrap_up();
  end
endmodule : test_pmbus_command_buffer_busy_handshake
`default_nettype wire
